/* File: logic/ccg_pkg.sv */
package ccg_pkg;

  // Register bus shape
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [ADDR_W-1:0] SLOW_OSC_MODE_ADDR = 16'hff58;
  localparam logic [ADDR_W-1:0] PERIPH_DIV_ADDR    = 16'hfff3;
  localparam logic [ADDR_W-1:0] STAB_SEL_ADDR      = 16'hfff4;
  localparam logic [ADDR_W-1:0] CPU_DIV_ADDR       = 16'hfffb;

  // Reset values
  localparam logic [DATA_W-1:0] CPU_DIV_RST    = 8'h02;
  localparam logic [DATA_W-1:0] PERIPH_DIV_RST = 8'h02;
  localparam logic [DATA_W-1:0] SLOW_OSC_RST   = 8'h00;

  // Implemented bits; all others are fixed zero
  localparam logic [DATA_W-1:0] CPU_DIV_MASK    = 8'h02;
  localparam logic [DATA_W-1:0] PERIPH_DIV_MASK = 8'h03;
  localparam logic [DATA_W-1:0] SLOW_OSC_MASK   = 8'h01;
  localparam logic [DATA_W-1:0] STAB_SEL_MASK   = 8'h03;

  // Field positions
  localparam int CPU_DIV_BIT1_POS   = 1;
  localparam int PERIPH_DIV_LO_POS  = 0;
  localparam int SLOW_OSC_HALT_POS  = 0;
  localparam int STAB_SEL_LO_POS    = 0;

  // Stabilization waits, as powers of two of system clock periods
  localparam int STAB_EXP_00 = 10;
  localparam int STAB_EXP_01 = 12;
  localparam int STAB_EXP_10 = 15;
  localparam int STAB_EXP_11 = 17;
  localparam int STAB_CNT_W  = 18;

  // Prescaler
  localparam int PRESC_W            = 4;
  localparam int MIN_INSTR_CPU_CLKS = 2;

  typedef enum logic [1:0] {
    CLK_SRC_HIGH_INT,
    CLK_SRC_CRYSTAL,
    CLK_SRC_EXT,
    CLK_SRC_RSVD
  } ccg_clk_src_t;

  typedef enum logic [2:0] {
    S_START,
    S_RUN,
    S_STOP,
    S_OSC_WAIT,
    S_STAB
  } ccg_state_t;

endpackage : ccg_pkg

/* File: logic/ccg_prescaler.sv */
`timescale 1ns/1ps
module ccg_prescaler
  import ccg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Configuration
  input  wire logic       runEn,
  input  wire logic [1:0] periphExp,
  input  wire logic [2:0] cpuExp,
  // Clock enables
  output logic            periphTick,
  output logic            cpuTick
);

  logic [PRESC_W-1:0] cnt_reg;
  logic [PRESC_W-1:0] cnt_next;
  logic [PRESC_W-1:0] periphMask;
  logic [PRESC_W-1:0] cpuMask;
  logic               periphHit;
  logic               cpuHit;

  // Free-running counter keeps both enables in one phase
  assign cnt_next   = cnt_reg + PRESC_W'(1);
  assign periphMask = PRESC_W'((5'h01 << periphExp) - 5'h01);
  assign cpuMask    = PRESC_W'((5'h01 << cpuExp) - 5'h01);
  assign periphHit  = (cnt_reg & periphMask) == periphMask;
  assign cpuHit     = (cnt_reg & cpuMask) == cpuMask;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_reg    <= '0;
      periphTick <= 1'b0;
      cpuTick    <= 1'b0;
    end
    else
    begin
      cnt_reg    <= cnt_next;
      periphTick <= runEn && periphHit;
      cpuTick    <= runEn && cpuHit;
    end
  end

  a_periph_half : assert property (@(posedge clk) disable iff (reset)
    (periphTick && $past(periphExp) == 2'h1) |-> $past(cnt_reg[0]))
    else $error("peripheral half rate tick off phase");

  a_periph_quarter : assert property (@(posedge clk) disable iff (reset)
    (periphTick && $past(periphExp) == 2'h2)
      |-> $past(cnt_reg[1:0]) == 2'h3)
    else $error("peripheral quarter rate tick off phase");

  a_cpu_divide : assert property (@(posedge clk) disable iff (reset)
    (cpuTick && $past(cpuExp) == 3'h4) |-> $past(cnt_reg) == 4'hf)
    else $error("cpu divide by sixteen tick off phase");

endmodule : ccg_prescaler

/* File: logic/ccg_clock_control.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Reset loads both divider registers with 02H
// - CPU clock from three divider bits
// - Peripheral divider 01H gives half system clock
// - Peripheral divider 02H gives quarter system clock
// - Divider registers take bit and byte writes
// - Shortest instruction spans two CPU clocks
// - Locked slow oscillator ignores mode writes
// - Locked slow oscillator fixes watchdog clock source
// - Slow oscillator mode resets 00H, bit/byte writes
// - Halt bit stops slow oscillator when allowed
// - Selected wait only after STOP with crystal
// - No wait for internal or external clock
// - Stabilization select accepts byte writes only
// - Stabilization select has no reset value
// - Codes select 2^10, 2^12, 2^15, 2^17 cycles
// - Wait counts from oscillation start only
// - Reset start uses option byte source and wait
// - System clock source chosen by option byte
module ccg_clock_control
  import ccg_pkg::*;
#(
  parameter logic [STAB_CNT_W-1:0] STAB_CYC_00 = STAB_CNT_W'(1) << STAB_EXP_00,
  parameter logic [STAB_CNT_W-1:0] STAB_CYC_01 = STAB_CNT_W'(1) << STAB_EXP_01,
  parameter logic [STAB_CNT_W-1:0] STAB_CYC_10 = STAB_CNT_W'(1) << STAB_EXP_10,
  parameter logic [STAB_CNT_W-1:0] STAB_CYC_11 = STAB_CNT_W'(1) << STAB_EXP_11
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Register access
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              byteWrite,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              bitWrite,
  input  wire logic [2:0]        bitIndex,
  input  wire logic              bitValue,
  input  wire logic              readEn,
  output logic [DATA_W-1:0]      rdData,
  output logic                   rdValid,
  // Option byte settings
  input  wire logic [1:0]        optClkSource,
  input  wire logic [1:0]        optStabSel,
  input  wire logic              optSoftStopAllowed,
  // CPU standby and oscillator status
  input  wire logic              stopMode,
  input  wire logic              oscStartedAsync,
  // Clock enables and controls
  output logic                   cpuTick,
  output logic                   periphTick,
  output logic                   instrTick,
  output logic [1:0]             sysClkSel,
  output logic                   slowOscRun,
  output logic                   wdtSrcFixedSlow,
  output logic                   stabWaiting,
  output logic                   cpuRunning
);

  localparam int INSTR_W = $clog2(MIN_INSTR_CPU_CLKS);

  logic [DATA_W-1:0]     cpuDiv_reg;
  logic [DATA_W-1:0]     periphDiv_reg;
  logic [DATA_W-1:0]     slowOsc_reg;
  logic [DATA_W-1:0]     stabSel_reg;
  logic [DATA_W-1:0]     cpuDiv_next;
  logic [DATA_W-1:0]     periphDiv_next;
  logic [DATA_W-1:0]     slowOsc_next;
  logic [DATA_W-1:0]     stabSel_next;
  ccg_state_t            state_reg;
  ccg_state_t            state_next;
  logic [STAB_CNT_W-1:0] stabCnt_reg;
  logic [STAB_CNT_W-1:0] stabCnt_next;
  logic                  fromReset_reg;
  logic                  fromReset_next;
  logic [INSTR_W-1:0]    instrCnt_reg;
  logic                  oscSync1_reg;
  logic                  oscSync2_reg;
  logic                  cpuTickInt;
  logic                  periphTickInt;

  // Address decode
  logic                  hitCpuDiv;
  logic                  hitPeriphDiv;
  logic                  hitSlowOsc;
  logic                  hitStabSel;
  logic [DATA_W-1:0]     bitMask;
  logic [DATA_W-1:0]     readMux;

  assign hitCpuDiv    = regAddr == CPU_DIV_ADDR;
  assign hitPeriphDiv = regAddr == PERIPH_DIV_ADDR;
  assign hitSlowOsc   = regAddr == SLOW_OSC_MODE_ADDR;
  assign hitStabSel   = regAddr == STAB_SEL_ADDR;
  assign bitMask      = DATA_W'(8'h01) << bitIndex;

  // Bit write merges into the old value, byte write wins when both
  function automatic logic [DATA_W-1:0] merge_write(
    input logic [DATA_W-1:0] oldVal,
    input logic              doByte,
    input logic              doBit,
    input logic [DATA_W-1:0] byteVal,
    input logic [DATA_W-1:0] bMask,
    input logic              bVal,
    input logic [DATA_W-1:0] implMask
  );
    logic [DATA_W-1:0] newVal;
    newVal = oldVal;
    if (doByte)
      newVal = byteVal;
    else if (doBit)
      newVal = bVal ? (oldVal | bMask) : (oldVal & ~bMask);
    return newVal & implMask;
  endfunction : merge_write

  assign cpuDiv_next = merge_write(cpuDiv_reg, byteWrite && hitCpuDiv,
    bitWrite && hitCpuDiv, wrData, bitMask, bitValue, CPU_DIV_MASK);
  assign periphDiv_next = merge_write(periphDiv_reg,
    byteWrite && hitPeriphDiv, bitWrite && hitPeriphDiv, wrData, bitMask,
    bitValue, PERIPH_DIV_MASK);
  // Writes dropped while the option byte locks the oscillator on
  assign slowOsc_next = merge_write(slowOsc_reg,
    byteWrite && hitSlowOsc && optSoftStopAllowed,
    bitWrite && hitSlowOsc && optSoftStopAllowed, wrData, bitMask,
    bitValue, SLOW_OSC_MASK);
  // Single bit manipulation has no effect here
  assign stabSel_next = merge_write(stabSel_reg, byteWrite && hitStabSel,
    1'b0, wrData, bitMask, bitValue, STAB_SEL_MASK);

  assign readMux = hitCpuDiv    ? cpuDiv_reg :
                   hitPeriphDiv ? periphDiv_reg :
                   hitSlowOsc   ? slowOsc_reg :
                   hitStabSel   ? stabSel_reg : 8'h00;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cpuDiv_reg    <= CPU_DIV_RST;
      periphDiv_reg <= PERIPH_DIV_RST;
      slowOsc_reg   <= SLOW_OSC_RST;
      rdData        <= 8'h00;
      rdValid       <= 1'b0;
    end
    else
    begin
      cpuDiv_reg    <= cpuDiv_next;
      periphDiv_reg <= periphDiv_next;
      slowOsc_reg   <= slowOsc_next;
      rdData        <= readEn ? readMux : 8'h00;
      rdValid       <= readEn;
    end
  end

  // Left without reset: contents undefined until software writes
  always_ff @(posedge clk)
  begin
    stabSel_reg <= stabSel_next;
  end

  // Divide ratio decode; prohibited peripheral code acts as quarter rate
  logic [1:0] periphExp;
  logic [2:0] cpuExp;
  logic [1:0] ppBits;

  assign ppBits    = periphDiv_reg[PERIPH_DIV_LO_POS +: 2];
  assign periphExp = (ppBits == 2'h0) ? 2'h0 :
                     (ppBits == 2'h1) ? 2'h1 : 2'h2;
  assign cpuExp    = {1'b0, periphExp} +
                     (cpuDiv_reg[CPU_DIV_BIT1_POS] ? 3'h2 : 3'h0);

  // Oscillator start flag crosses from the analog side
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      oscSync1_reg <= 1'b0;
      oscSync2_reg <= 1'b0;
    end
    else
    begin
      oscSync1_reg <= oscStartedAsync;
      oscSync2_reg <= oscSync1_reg;
    end
  end

  // Stabilization wait selection
  logic [STAB_CNT_W-1:0] regStabCycles;
  logic [STAB_CNT_W-1:0] optStabCycles;
  logic [1:0]            regStabCode;
  logic                  srcIsCrystal;

  assign regStabCode   = stabSel_reg[STAB_SEL_LO_POS +: 2];
  assign regStabCycles = (regStabCode == 2'h0) ? STAB_CYC_00 :
                         (regStabCode == 2'h1) ? STAB_CYC_01 :
                         (regStabCode == 2'h2) ? STAB_CYC_10 : STAB_CYC_11;
  assign optStabCycles = (optStabSel == 2'h0) ? STAB_CYC_00 :
                         (optStabSel == 2'h1) ? STAB_CYC_01 :
                         (optStabSel == 2'h2) ? STAB_CYC_10 : STAB_CYC_11;
  assign srcIsCrystal  = optClkSource == CLK_SRC_CRYSTAL;

  always_comb
  begin
    state_next     = state_reg;
    stabCnt_next   = stabCnt_reg;
    fromReset_next = fromReset_reg;
    unique case (state_reg)
      S_START:
      begin
        fromReset_next = 1'b1;
        state_next     = srcIsCrystal ? S_OSC_WAIT : S_RUN;
      end
      S_RUN:
      begin
        if (stopMode)
          state_next = S_STOP;
      end
      S_STOP:
      begin
        if (!stopMode)
        begin
          fromReset_next = 1'b0;
          state_next     = srcIsCrystal ? S_OSC_WAIT : S_RUN;
        end
      end
      S_OSC_WAIT:
      begin
        // Time before oscillation starts is not counted
        if (oscSync2_reg)
        begin
          state_next   = S_STAB;
          stabCnt_next = fromReset_reg ? optStabCycles :
                                         regStabCycles;
        end
      end
      S_STAB:
      begin
        if (stabCnt_reg <= STAB_CNT_W'(1))
          state_next = S_RUN;
        else
          stabCnt_next = stabCnt_reg - STAB_CNT_W'(1);
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg     <= S_START;
      stabCnt_reg   <= '0;
      fromReset_reg <= 1'b1;
    end
    else
    begin
      state_reg     <= state_next;
      stabCnt_reg   <= stabCnt_next;
      fromReset_reg <= fromReset_next;
    end
  end

  ccg_prescaler u_prescaler (
    .clk        (clk),
    .reset      (reset),
    .runEn      (state_reg == S_RUN),
    .periphExp  (periphExp),
    .cpuExp     (cpuExp),
    .periphTick (periphTickInt),
    .cpuTick    (cpuTickInt)
  );

  // Registered control outputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cpuTick         <= 1'b0;
      periphTick      <= 1'b0;
      instrTick       <= 1'b0;
      instrCnt_reg    <= '0;
      sysClkSel       <= CLK_SRC_HIGH_INT;
      slowOscRun      <= 1'b1;
      wdtSrcFixedSlow <= 1'b0;
      stabWaiting     <= 1'b0;
      cpuRunning      <= 1'b0;
    end
    else
    begin
      cpuTick    <= cpuTickInt;
      periphTick <= periphTickInt;
      if (cpuTickInt)
      begin
        if (instrCnt_reg == INSTR_W'(MIN_INSTR_CPU_CLKS - 1))
          instrCnt_reg <= '0;
        else
          instrCnt_reg <= instrCnt_reg + INSTR_W'(1);
      end
      instrTick <= cpuTickInt &&
                   (instrCnt_reg == INSTR_W'(MIN_INSTR_CPU_CLKS - 1));
      sysClkSel <= optClkSource;
      slowOscRun <= !optSoftStopAllowed ||
                    !slowOsc_reg[SLOW_OSC_HALT_POS];
      wdtSrcFixedSlow <= !optSoftStopAllowed;
      stabWaiting <= (state_next == S_OSC_WAIT) || (state_next == S_STAB);
      cpuRunning  <= state_next == S_RUN;
    end
  end

  a_reset_dividers : assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> cpuDiv_reg == CPU_DIV_RST &&
                      periphDiv_reg == PERIPH_DIV_RST &&
                      slowOsc_reg == SLOW_OSC_RST)
    else $error("reset values wrong after release");

  a_bit_write_div : assert property (@(posedge clk) disable iff (reset)
    (bitWrite && !byteWrite && hitCpuDiv && bitIndex == 3'h1)
      |=> cpuDiv_reg[CPU_DIV_BIT1_POS] == $past(bitValue))
    else $error("bit write to cpu divider lost");

  a_locked_osc : assert property (@(posedge clk) disable iff (reset)
    (!optSoftStopAllowed && (byteWrite || bitWrite) && hitSlowOsc)
      |=> $stable(slowOsc_reg) ##1 slowOscRun)
    else $error("locked slow oscillator register changed");

  a_wdt_fixed : assert property (@(posedge clk) disable iff (reset)
    !optSoftStopAllowed |=> wdtSrcFixedSlow)
    else $error("watchdog source not fixed");

  a_halt_bit : assert property (@(posedge clk) disable iff (reset)
    (optSoftStopAllowed && byteWrite && hitSlowOsc && wrData[0])
      |=> ##1 !slowOscRun)
    else $error("slow oscillator not stopped");

  a_stab_byte_only : assert property (@(posedge clk) disable iff (reset)
    (bitWrite && !byteWrite) |=> $stable(stabSel_reg))
    else $error("bit write changed stabilization select");

  a_fixed_zero : assert property (@(posedge clk) disable iff (reset)
    (byteWrite && wrData == 8'hff && (hitCpuDiv || hitPeriphDiv))
      |=> (cpuDiv_reg & ~CPU_DIV_MASK) == 8'h00 &&
          (periphDiv_reg & ~PERIPH_DIV_MASK) == 8'h00)
    else $error("fixed zero bit became set");

  a_no_wait : assert property (@(posedge clk) disable iff (reset)
    (state_reg == S_STOP && !stopMode && !srcIsCrystal)
      |=> state_reg == S_RUN ##1 cpuRunning)
    else $error("wait inserted for non crystal source");

  a_osc_hold : assert property (@(posedge clk) disable iff (reset)
    (state_reg == S_OSC_WAIT && !oscSync2_reg) |=> state_reg == S_OSC_WAIT)
    else $error("wait started before oscillation");

  a_stab_load : assert property (@(posedge clk) disable iff (reset)
    (state_reg == S_OSC_WAIT && oscSync2_reg && !fromReset_reg)
      |=> state_reg == S_STAB && stabCnt_reg == $past(regStabCycles))
    else $error("stabilization count loaded wrong");

  a_stab_end : assert property (@(posedge clk) disable iff (reset)
    (state_reg == S_STAB && stabCnt_reg == STAB_CNT_W'(1))
      |=> state_reg == S_RUN ##1 cpuRunning && !stabWaiting)
    else $error("stabilization wait did not end");

  a_reset_start : assert property (@(posedge clk) disable iff (reset)
    (state_reg == S_OSC_WAIT && oscSync2_reg && fromReset_reg)
      |=> stabCnt_reg == $past(optStabCycles))
    else $error("reset start ignored option wait");

endmodule : ccg_clock_control

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import ccg_pkg::*;
;
  logic              clk;
  logic              reset;
  logic [ADDR_W-1:0] regAddr;
  logic              byteWrite;
  logic [DATA_W-1:0] wrData;
  logic              bitWrite;
  logic [2:0]        bitIndex;
  logic              bitValue;
  logic              readEn;
  logic [DATA_W-1:0] rdData;
  logic              rdValid;
  logic [1:0]        optClkSource;
  logic [1:0]        optStabSel;
  logic              optSoftStopAllowed;
  logic              stopMode;
  logic              oscStartedAsync;
  logic              cpuTick;
  logic              periphTick;
  logic              instrTick;
  logic [1:0]        sysClkSel;
  logic              slowOscRun;
  logic              wdtSrcFixedSlow;
  logic              stabWaiting;
  logic              cpuRunning;
  int                fails;
  int                checked;
  logic [7:0]        expQ[$];
  logic [7:0]        lfsrState;
  int                stabLen[4];
  int                d;
  int                c;
  int                p;
  int                t;
  bit                sawWait;

  // Shortened stabilization waits
  ccg_clock_control #(
    .STAB_CYC_00 (STAB_CNT_W'(4)),
    .STAB_CYC_01 (STAB_CNT_W'(8)),
    .STAB_CYC_10 (STAB_CNT_W'(16)),
    .STAB_CYC_11 (STAB_CNT_W'(32))
  ) dut_u (
    .clk(clk), .reset(reset), .regAddr(regAddr), .byteWrite(byteWrite),
    .wrData(wrData), .bitWrite(bitWrite), .bitIndex(bitIndex),
    .bitValue(bitValue), .readEn(readEn), .rdData(rdData),
    .rdValid(rdValid), .optClkSource(optClkSource),
    .optStabSel(optStabSel), .optSoftStopAllowed(optSoftStopAllowed),
    .stopMode(stopMode), .oscStartedAsync(oscStartedAsync),
    .cpuTick(cpuTick), .periphTick(periphTick), .instrTick(instrTick),
    .sysClkSel(sysClkSel), .slowOscRun(slowOscRun),
    .wdtSrcFixedSlow(wdtSrcFixedSlow), .stabWaiting(stabWaiting),
    .cpuRunning(cpuRunning)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  task automatic give_verdict();
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    regAddr   = a;
    wrData    = v;
    byteWrite = 1'b1;
    @(negedge clk);
    byteWrite = 1'b0;
  endtask : wr

  task automatic bitw(input logic [15:0] a, input logic [2:0] i, input bit v);
    @(negedge clk);
    regAddr  = a;
    bitIndex = i;
    bitValue = v;
    bitWrite = 1'b1;
    @(negedge clk);
    bitWrite = 1'b0;
  endtask : bitw

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    regAddr = a;
    readEn  = 1'b1;
    expQ.push_back(e);
    @(negedge clk);
    readEn = 1'b0;
  endtask : rd

  // Cycles until the CPU runs again, noting any wait phase
  task automatic wait_run(output int n, output bit w);
    n = 0;
    w = 0;
    while (cpuRunning !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
      if (stabWaiting === 1'b1)
        w = 1;
    end
  endtask : wait_run

  task automatic stop_cycle(input bit xtal, output int n, output bit w);
    @(negedge clk);
    stopMode = 1'b1;
    // Resonator stops with STOP and restarts only after release
    if (xtal)
      oscStartedAsync = 1'b0;
    repeat (4) @(negedge clk);
    stopMode = 1'b0;
    if (xtal)
    begin
      repeat (5) @(negedge clk);
      chk(stabWaiting, 1);
      chk(cpuRunning, 0);
      oscStartedAsync = 1'b1;
    end
    wait_run(n, w);
  endtask : stop_cycle

  // Read results checked in order of request
  initial
  begin
    forever
    begin
      @(negedge clk);
      if (rdValid === 1'b1)
      begin
        if (expQ.size() == 0)
          chk(1, 0);
        else
          chk(rdData, expQ.pop_front());
      end
    end
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict();
  end

  initial
  begin
    {regAddr, byteWrite, wrData, bitWrite, bitIndex, bitValue} = '0;
    readEn = 1'b0;
    optClkSource = 2'h0;
    optStabSel = 2'h0;
    optSoftStopAllowed = 1'b1;
    stopMode = 1'b0;
    oscStartedAsync = 1'b1;
    reset = 1'b1;
    lfsrState = 8'h47;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    rd(CPU_DIV_ADDR, 8'h02);
    rd(PERIPH_DIV_ADDR, 8'h02);
    rd(SLOW_OSC_MODE_ADDR, 8'h00);
    // Random bytes into every register
    for (int k = 0; k < 8; k++)
    begin
      lfsrState = lfsr_next(lfsrState);
      wr(CPU_DIV_ADDR, lfsrState);
      wr(PERIPH_DIV_ADDR, lfsrState);
      wr(STAB_SEL_ADDR, lfsrState);
      wr(SLOW_OSC_MODE_ADDR, lfsrState);
      wr(16'hff00, lfsrState);
      rd(CPU_DIV_ADDR, lfsrState & CPU_DIV_MASK);
      rd(PERIPH_DIV_ADDR, lfsrState & PERIPH_DIV_MASK);
      rd(STAB_SEL_ADDR, lfsrState & STAB_SEL_MASK);
      rd(SLOW_OSC_MODE_ADDR, lfsrState & SLOW_OSC_MASK);
      rd(16'hff00, 8'h00);
    end
    wr(STAB_SEL_ADDR, 8'h03);
    bitw(STAB_SEL_ADDR, 3'h1, 1'b0);
    rd(STAB_SEL_ADDR, 8'h03);
    wr(SLOW_OSC_MODE_ADDR, 8'h00);
    // Every divider combination except prohibited peripheral code 3
    for (int pp = 0; pp < 3; pp++)
      for (int b = 0; b < 2; b++)
      begin
        wr(PERIPH_DIV_ADDR, 8'(pp));
        bitw(CPU_DIV_ADDR, 3'h1, b[0]);
        repeat (8) @(negedge clk);
        c = 0;
        p = 0;
        t = 0;
        repeat (64)
        begin
          @(negedge clk);
          c += (cpuTick === 1'b1);
          p += (periphTick === 1'b1);
          t += (instrTick === 1'b1);
        end
        d = (1 << pp) * (b ? 4 : 1);
        chk(c, 64 / d);
        chk(p, 64 >> pp);
        chk(t, 32 / d);
      end
    // Slow oscillator halt, then locked by option
    bitw(SLOW_OSC_MODE_ADDR, 3'h0, 1'b1);
    repeat (3) @(negedge clk);
    chk(slowOscRun, 0);
    chk(wdtSrcFixedSlow, 0);
    optSoftStopAllowed = 1'b0;
    repeat (3) @(negedge clk);
    chk(slowOscRun, 1);
    chk(wdtSrcFixedSlow, 1);
    wr(SLOW_OSC_MODE_ADDR, 8'h00);
    rd(SLOW_OSC_MODE_ADDR, 8'h01);
    optSoftStopAllowed = 1'b1;
    wr(SLOW_OSC_MODE_ADDR, 8'h00);
    repeat (3) @(negedge clk);
    chk(slowOscRun, 1);
    // STOP release without crystal
    for (int s = 0; s < 3; s += 2)
    begin
      optClkSource = 2'(s);
      repeat (3) @(negedge clk);
      chk(sysClkSel, s);
      stop_cycle(1'b0, d, sawWait);
      chk(sawWait, 0);
      chk(d <= 3, 1);
    end
    // STOP release with crystal, every wait code
    optClkSource = 2'h1;
    for (int k = 0; k < 4; k++)
    begin
      wr(STAB_SEL_ADDR, 8'(k));
      stop_cycle(1'b1, stabLen[k], sawWait);
      chk(stabLen[k] - stabLen[0], (4 << k) - 4);
    end
    chk(stabLen[0] >= 4 && stabLen[0] <= 10, 1);
    chk(sysClkSel, 2'h1);
    // Reset start takes the option wait code
    optStabSel = 2'h2;
    wr(STAB_SEL_ADDR, 8'h00);
    @(negedge clk);
    reset = 1'b1;
    oscStartedAsync = 1'b0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (5) @(negedge clk);
    chk(stabWaiting, 1);
    oscStartedAsync = 1'b1;
    wait_run(d, sawWait);
    chk(d, stabLen[2]);
    rd(CPU_DIV_ADDR, 8'h02);
    repeat (4) @(negedge clk);
    chk(expQ.size(), 0);
    give_verdict();
  end
endmodule : tb_top
